// ==== core/vpiu_core.sv ====
// vectored priority interrupt unit: pending, arbitration, nesting, wake
module vpiu_core import vpiu_pkg::*; (
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic [SRC_N-1:0] periph_evt_i,
   input wire logic [SRC_N-1:0] src_enable_i,
   input wire logic [SRC_N-1:0] src_clear_i,
   input wire logic [PIN_N-1:0] ext_pin_i,
   input vpiu_pin_mode_t [PIN_N-1:0] pin_mode_i,
   input vpiu_level_t [VEC_N-1:0] vec_level_i,
   input wire logic global_enable_i,
   input wire logic [EXC_N-1:0] exc_evt_i,
   input wire logic [EXC_N-1:0] exc_clear_i,
   input wire logic [EXC_N-1:0] exception_enable_low_i,
   input wire logic exception_enable_high_i,
   input wire logic irq_ack_i,
   input wire logic irq_ret_i,
   input wire logic sleep_enter_i,
   output logic irq_req_o,
   output vpiu_call_t irq_call_o,
   output logic [SRC_N-1:0] pending_o,
   output logic [EXC_N-1:0] exc_pending_o,
   output logic sleep_o
);
   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   logic [SRC_N-1:0] pend_reg, pend_next;
   logic [EXC_N-1:0] exc_pend_reg, exc_pend_next;
   logic [PIN_N-1:0] pin_prev_reg;
   logic [LVL_N-1:0] isr_reg, isr_next;
   logic exc_isr_reg, exc_isr_next;
   logic req_reg, req_next;
   vpiu_call_t call_reg, call_next;
   logic sleep_reg, sleep_next;

   logic [SRC_N-1:0] evt;
   logic [VEC_N-1:0] vreq;
   logic [1:0] cur_lvl;
   logic [1:0] best_lvl;
   logic [3:0] best_idx;
   logic best_ok;
   logic exc_req;
   logic any_irq;

   // -----------------------------------------------------------------
   // pin detection and source events
   // -----------------------------------------------------------------
   always_comb begin
      evt = periph_evt_i;
      for (int p = 0; p < PIN_N; p++) begin
         unique case (pin_mode_i[p])
            PIN_HIGH: evt[PIN_SRC[p]] = evt[PIN_SRC[p]] | ext_pin_i[p];
            PIN_LOW: evt[PIN_SRC[p]] = evt[PIN_SRC[p]] | ~ext_pin_i[p];
            PIN_RISE: evt[PIN_SRC[p]] = evt[PIN_SRC[p]] |
               (ext_pin_i[p] & ~pin_prev_reg[p]);
            PIN_FALL: evt[PIN_SRC[p]] = evt[PIN_SRC[p]] |
               (~ext_pin_i[p] & pin_prev_reg[p]);
            PIN_BOTH: evt[PIN_SRC[p]] = evt[PIN_SRC[p]] |
               (ext_pin_i[p] ^ pin_prev_reg[p]);
            default: evt[PIN_SRC[p]] = evt[PIN_SRC[p]];
         endcase
      end
   end

   // -----------------------------------------------------------------
   // pending flags: an event in the clear cycle wins
   // -----------------------------------------------------------------
   always_comb begin
      pend_next = (pend_reg & ~src_clear_i) | evt;
      exc_pend_next = (exc_pend_reg & ~exc_clear_i) | exc_evt_i;
   end

   // -----------------------------------------------------------------
   // arbitration
   // -----------------------------------------------------------------
   always_comb begin
      vreq = '0;
      for (int s = 0; s < SRC_N; s++) begin
         vreq[SRC_VEC[s]] = vreq[SRC_VEC[s]] |
            (pend_reg[s] & src_enable_i[s]);
      end
   end

   // level in service: 0 none, else highest nested level plus one
   always_comb begin
      cur_lvl = 2'h0;
      for (int l = 0; l < LVL_N; l++) begin
         if (isr_reg[l]) begin
            cur_lvl = 2'(l + 1);
         end
      end
   end

   // downward scan with >= leaves the lowest index on a tie
   always_comb begin
      best_ok = 1'b0;
      best_lvl = 2'h0;
      best_idx = 4'h0;
      for (int v = VEC_N - 1; v >= 0; v--) begin
         if (vreq[v] && (!best_ok || vec_level_i[v] >= best_lvl)) begin
            best_ok = 1'b1;
            best_lvl = vec_level_i[v];
            best_idx = 4'(v);
         end
      end
   end

   // exceptions skip the global flag on purpose
   assign exc_req = exception_enable_high_i &&
      |(exc_pend_reg & exception_enable_low_i);
   assign any_irq = exc_req || (|vreq);

   always_comb begin
      req_next = 1'b0;
      call_next = call_reg;
      // the ack cycle drops the request so it is not taken twice
      if (!irq_ack_i && !exc_isr_reg) begin
         if (exc_req) begin
            req_next = 1'b1;
            call_next.exc = 1'b1;
            call_next.level = 2'h0;
            call_next.addr = EXC_ADDR;
            call_next.push_bytes = STACK_VEC_BYTES;
         end else if (best_ok && global_enable_i &&
                      ({1'b0, best_lvl} + 3'h1) > {1'b0, cur_lvl}) begin
            req_next = 1'b1;
            call_next.exc = 1'b0;
            call_next.level = best_lvl;
            call_next.addr = VEC_BASE +
               ADDR_W'({best_idx, VEC_SHIFT'(0)});
            call_next.push_bytes = STACK_VEC_BYTES;
         end
      end
   end

   // -----------------------------------------------------------------
   // nesting of service levels
   // -----------------------------------------------------------------
   always_comb begin
      isr_next = isr_reg;
      exc_isr_next = exc_isr_reg;
      if (irq_ret_i) begin
         if (exc_isr_reg) begin
            exc_isr_next = 1'b0;
         end else if (cur_lvl != 2'h0) begin
            isr_next[cur_lvl - 2'h1] = 1'b0;
         end
      end
      if (irq_ack_i && req_reg) begin
         if (call_reg.exc) begin
            exc_isr_next = 1'b1;
         end else begin
            isr_next[call_reg.level] = 1'b1;
         end
      end
   end

   // -----------------------------------------------------------------
   // light sleep: wake wins over entry
   // -----------------------------------------------------------------
   always_comb begin
      sleep_next = sleep_reg | sleep_enter_i;
      if (any_irq) begin
         sleep_next = 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         pend_reg <= '0;
         exc_pend_reg <= '0;
         pin_prev_reg <= '0;
         isr_reg <= '0;
         exc_isr_reg <= 1'b0;
         req_reg <= 1'b0;
         call_reg <= '0;
         sleep_reg <= 1'b0;
      end else begin
         pend_reg <= pend_next;
         exc_pend_reg <= exc_pend_next;
         pin_prev_reg <= ext_pin_i;
         isr_reg <= isr_next;
         exc_isr_reg <= exc_isr_next;
         req_reg <= req_next;
         call_reg <= call_next;
         sleep_reg <= sleep_next;
      end
   end

   assign irq_req_o = req_reg;
   assign irq_call_o = call_reg;
   assign pending_o = pend_reg;
   assign exc_pending_o = exc_pend_reg;
   assign sleep_o = sleep_reg;

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   // check-only masks: requesters that would outrank the call on offer,
   // built from the levels themselves rather than from the scan result
   logic [VEC_N-1:0] lvl_above;
   logic [VEC_N-1:0] tie_below;

   always_comb begin
      for (int v = 0; v < VEC_N; v++) begin
         lvl_above[v] = vreq[v] && (vec_level_i[v] > call_next.level);
         tie_below[v] = vreq[v] && (vec_level_i[v] == call_next.level) &&
            (4'(v) < call_next.addr[5:2]);
      end
   end

   a_exc_wins: assert property (
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      exc_req && !exc_isr_reg && !irq_ack_i |=> irq_req_o &&
      irq_call_o.exc && irq_call_o.addr == EXC_ADDR)
      else $error("exception request not presented");
   a_exc_blocks_all: assert property (
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      exc_isr_reg |=> !irq_req_o)
      else $error("request raised during exception service");
   a_level_block: assert property (
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      irq_req_o && !irq_call_o.exc |->
      {1'b0, irq_call_o.level} + 3'h1 > {1'b0, $past(cur_lvl)})
      else $error("request at or below level in service");
   a_top_level: assert property (
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      irq_req_o && !irq_call_o.exc |-> $past(lvl_above) == '0)
      else $error("lower level granted over higher");
   a_tie_lowest: assert property (
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      irq_req_o && !irq_call_o.exc |-> $past(tie_below) == '0)
      else $error("tie not resolved to lowest vector");
   a_vec_range: assert property (
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      irq_req_o && !irq_call_o.exc |->
      irq_call_o.addr >= VEC_BASE && irq_call_o.addr <= VEC_LAST &&
      irq_call_o.addr[1:0] == 2'h0)
      else $error("peripheral vector out of table");
   a_shared_vec: assert property (
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      irq_req_o && irq_call_o.addr == VEC_SHARED |->
      $past(vreq[SHARED_IDX]))
      else $error("shared vector without a request");
   a_push_six: assert property (
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      irq_req_o |-> irq_call_o.push_bytes == STACK_VEC_BYTES &&
      irq_call_o.push_bytes != STACK_CALL_BYTES)
      else $error("vector call stack size wrong");
   a_sleep_wake: assert property (
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      sleep_o && any_irq |=> !sleep_o)
      else $error("interrupt did not end sleep");
   a_pend_hold: assert property (
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      ($past(pend_reg) & ~$past(src_clear_i) & ~pend_reg) == '0)
      else $error("pending flag lost without clear");
endmodule // vpiu_core

// ==== pkg/vpiu_pkg.sv ====
// shared constants and types of the vectored priority interrupt unit
package vpiu_pkg;
   // -----------------------------------------------------------------
   // sizes
   // -----------------------------------------------------------------
   localparam int unsigned SRC_N = 40;
   localparam int unsigned VEC_N = 16;
   localparam int unsigned EXC_N = 5;
   localparam int unsigned PIN_N = 8;
   localparam int unsigned LVL_N = 3;
   localparam int unsigned ADDR_W = 20;

   // -----------------------------------------------------------------
   // vector addresses
   // -----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] VEC_BASE = 20'h08000;
   localparam logic [ADDR_W-1:0] VEC_LAST = 20'h0803C;
   localparam logic [ADDR_W-1:0] VEC_SHARED = 20'h08018;
   localparam logic [ADDR_W-1:0] EXC_ADDR = 20'h08080;
   localparam int unsigned VEC_SHIFT = 2;
   localparam logic [3:0] SHARED_IDX = 4'h6;

   // stack cost of a vectored call versus a call without status save
   localparam logic [2:0] STACK_VEC_BYTES = 3'h6;
   localparam logic [2:0] STACK_CALL_BYTES = 3'h4;

   // vector index of each source, source 0 first
   localparam logic [3:0] SRC_VEC [SRC_N] = '{
      4'h0, 4'h1, 4'h1, 4'h2, 4'h2, 4'h3, 4'h5,
      4'h6, 4'h6, 4'h6, 4'h6, 4'h6, 4'h6, 4'h6,
      4'h7, 4'h7, 4'h7, 4'h7, 4'h7, 4'h7,
      4'h8, 4'h8, 4'h8, 4'h9, 4'h9, 4'h9, 4'h9,
      4'hA, 4'hA, 4'hA, 4'hB, 4'hC, 4'hC, 4'hD,
      4'hE, 4'hE, 4'hE, 4'hF, 4'hF, 4'hF};

   // source slot fed by external pin interrupt 0..7
   localparam int unsigned PIN_SRC [PIN_N] = '{5, 6, 7, 14, 20, 23, 33, 34};

   // -----------------------------------------------------------------
   // types
   // -----------------------------------------------------------------
   typedef logic [1:0] vpiu_level_t;

   typedef enum logic [2:0] {
      PIN_HIGH, PIN_LOW, PIN_RISE, PIN_FALL, PIN_BOTH
   } vpiu_pin_mode_t;

   typedef struct packed {
      logic exc;
      vpiu_level_t level;
      logic [ADDR_W-1:0] addr;
      logic [2:0] push_bytes;
   } vpiu_call_t;
endpackage

// ==== sim/vpiu_core_tb.sv ====
// self-checking bench of the vectored priority interrupt unit
module vpiu_core_tb import vpiu_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst = 1'b1, gen, sleep_in, slow, xenh, req, ack;
   logic ret, sleep, hi;
   logic [SRC_N-1:0] evt, en, clr, pend;
   logic [EXC_N-1:0] xevt, xclr, xenl, xpend;
   logic [PIN_N-1:0] pin, p0, p1, x, g;
   vpiu_pin_mode_t [PIN_N-1:0] pmode;
   vpiu_level_t [VEC_N-1:0] lvl;
   vpiu_call_t call;
   logic [7:0] svc;
   logic [1:0] depth;
   logic [27:0] exp_q[$];
   logic [27:0] e;
   int mismatches = 0, num_checks = 0, seed = 89234, i, j, w, l, k, m, t;
   vpiu_core i_vpiu_core (.ref_clk_i(clk), .sys_rst_i(rst),
      .periph_evt_i(evt), .src_enable_i(en), .src_clear_i(clr),
      .ext_pin_i(pin), .pin_mode_i(pmode), .vec_level_i(lvl),
      .global_enable_i(gen), .exc_evt_i(xevt), .exc_clear_i(xclr),
      .exception_enable_low_i(xenl), .exception_enable_high_i(xenh),
      .irq_ack_i(ack), .irq_ret_i(ret), .sleep_enter_i(sleep_in),
      .irq_req_o(req), .irq_call_o(call), .pending_o(pend),
      .exc_pending_o(xpend), .sleep_o(sleep));
   vpiu_cpu_model i_vpiu_cpu_model (.ref_clk_i(clk), .sys_rst_i(rst),
      .irq_req_i(req), .irq_call_i(call), .slow_i(slow), .svc_i(svc),
      .ack_o(ack), .ret_o(ret), .depth_o(depth));
   initial forever #2.5 clk = ~clk;
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task final_report;
      if (mismatches == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task chk(string n, logic [27:0] xv, logic [27:0] gv);
      num_checks++;
      if (gv !== xv) begin
         mismatches++;
         $display("CHECK FAILED %s exp %h got %h", n, xv, gv);
      end
   endtask
   task cyc(int n);
      repeat (n) @(negedge clk);
   endtask
   // expected call of a source, with the service depth at the take
   function logic [27:0] pc(int s, logic [1:0] d);
      return {d, 1'b0, lvl[SRC_VEC[s]], VEC_BASE + {SRC_VEC[s], 2'b00},
         STACK_VEC_BYTES};
   endfunction
   // software clears the taken source as soon as the call is taken
   task serve(int s);
      for (t = 0; t < 300 && !(req === 1'b1 && ack === 1'b1); t++) cyc(1);
      if (t == 300) begin
         mismatches++;
         final_report;
      end
      cyc(1);
      if (s < SRC_N) clr[s] = 1'b1;
      else xclr[s-SRC_N] = 1'b1;
      cyc(1);
      {clr, xclr} = '0;
   endtask
   task wait_idle;
      for (t = 0; t < 400 && depth !== 2'h0; t++) cyc(1);
      if (t == 400) begin
         mismatches++;
         final_report;
      end
      cyc(2);
   endtask
   always @(posedge clk) if (req === 1'b1 && ack === 1'b1) begin
      e = exp_q.size() ? exp_q.pop_front() : '1;
      chk("call", e, {depth, call});
   end
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      {evt, clr, pin, xevt, xclr, sleep_in, slow, lvl} = '0;
      {en, xenl, xenh, gen} = '1;
      svc = 8'd20;
      foreach (pmode[k]) pmode[k] = PIN_HIGH;
      cyc(5);
      rst = 1'b0;
      en = '0;
      for (m = 0; m < 5; m++) repeat (4) begin
         p0 = $random(seed);
         p1 = $random(seed);
         foreach (pmode[k]) pmode[k] = vpiu_pin_mode_t'(m);
         pin = p0;
         clr = '1;
         cyc(2);
         clr = '0;
         pin = p1;
         cyc(2);
         case (m)
            0: x = p1 | p0;
            1: x = ~p1 | ~p0;
            2: x = ~p0 & p1;
            3: x = p0 & ~p1;
            default: x = p0 ^ p1;
         endcase
         foreach (g[k]) g[k] = pend[PIN_SRC[k]];
         chk("pin", 28'(x), 28'(g));
      end
      foreach (pmode[k]) pmode[k] = PIN_HIGH;
      pin = '0;
      clr = '1;
      cyc(2);
      clr = '0;
      en = '1;
      for (i = 0; i < SRC_N; i++) begin
         j = {$random(seed)} % SRC_N;
         while (SRC_VEC[j] == SRC_VEC[i]) j = (j + 1) % SRC_N;
         foreach (lvl[k]) lvl[k] = vpiu_level_t'({$random(seed)} % 3);
         slow = $random(seed);
         if ($random(seed) & 1) begin
            hi = lvl[SRC_VEC[j]] > lvl[SRC_VEC[i]] ||
               (lvl[SRC_VEC[j]] == lvl[SRC_VEC[i]] && SRC_VEC[j] < SRC_VEC[i]);
            w = hi ? j : i;
            l = hi ? i : j;
            exp_q.push_back(pc(w, 2'h0));
            exp_q.push_back(pc(l, 2'h0));
            evt[i] = 1'b1;
            evt[j] = 1'b1;
            cyc(1);
            evt = '0;
            serve(w);
            serve(l);
         end else begin
            exp_q.push_back(pc(i, 2'h0));
            exp_q.push_back(pc(j, 2'(lvl[SRC_VEC[j]] > lvl[SRC_VEC[i]])));
            evt[i] = 1'b1;
            cyc(1);
            evt = '0;
            serve(i);
            evt[j] = 1'b1;
            cyc(1);
            evt = '0;
            serve(j);
         end
         wait_idle;
      end
      xenh = 1'b0;
      xevt[0] = 1'b1;
      cyc(1);
      xevt = '0;
      cyc(4);
      chk("masked", 28'h0, 28'(req));
      chk("xpend", 28'h1, 28'(xpend));
      exp_q.push_back({3'h1, 2'h0, EXC_ADDR, STACK_VEC_BYTES});
      xenh = 1'b1;
      serve(SRC_N);
      wait_idle;
      for (k = 0; k < EXC_N; k++) begin
         i = {$random(seed)} % SRC_N;
         lvl[SRC_VEC[i]] = 2'h2;
         // odd rounds leave the peripheral eligible: the exception must
         // still win on its own; even rounds show the global flag ignored
         gen = k[0];
         exp_q.push_back({3'h1, 2'h0, EXC_ADDR, STACK_VEC_BYTES});
         exp_q.push_back(pc(i, 2'h0));
         evt[i] = 1'b1;
         xevt[k] = 1'b1;
         cyc(1);
         {evt, xevt} = '0;
         serve(SRC_N + k);
         gen = 1'b1;
         serve(i);
         wait_idle;
      end
      gen = 1'b0;
      sleep_in = 1'b1;
      cyc(1);
      sleep_in = 1'b0;
      cyc(1);
      chk("sleep", 28'h1, 28'(sleep));
      evt[3] = 1'b1;
      cyc(1);
      evt = '0;
      cyc(2);
      chk("wake", 28'h0, 28'(sleep));
      chk("stack", 28'h1800, 28'(i_vpiu_cpu_model.sp_reg));
      clr[3] = 1'b1;
      cyc(1);
      clr = '0;
      sleep_in = 1'b1;
      cyc(1);
      sleep_in = 1'b0;
      cyc(1);
      chk("resleep", 28'h1, 28'(sleep));
      rst = 1'b1;
      cyc(1);
      chk("rst wake", 28'h0, 28'(sleep));
      cyc(4);
      rst = 1'b0;
      cyc(2);
      chk("queue", 28'h0, 28'(exp_q.size()));
      final_report;
   end
endmodule // vpiu_core_tb

// ==== sim/vpiu_cpu_model.sv ====
// cpu core model: takes offered calls, services them, then returns
module vpiu_cpu_model import vpiu_pkg::*; (
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic irq_req_i,
   input vpiu_call_t irq_call_i,
   input wire logic slow_i,
   input wire logic [7:0] svc_i,
   output logic ack_o,
   output logic ret_o,
   output logic [1:0] depth_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] tmr_reg;
   logic [1:0] tick_reg;
   logic [15:0] sp_reg;
   // ----------------------------------------------------------------
   // take, service timer and return
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      tick_reg <= tick_reg + 2'h1;
      ret_o <= 1'b0;
      // slow mode acks only one cycle in four
      ack_o <= irq_req_i & ~ack_o & (~slow_i | (tick_reg == 2'h3));
      if (sys_rst_i) begin
         {ack_o, tick_reg, depth_o, tmr_reg} <= '0;
         sp_reg <= 16'h1800;
      end else if (irq_req_i && ack_o) begin
         depth_o <= depth_o + 2'h1;
         tmr_reg <= svc_i;
         sp_reg <= sp_reg - 16'(irq_call_i.push_bytes);
      end else if (depth_o != 2'h0) begin
         // one return per service period, innermost first
         if (tmr_reg == 8'h00) begin
            ret_o <= 1'b1;
            depth_o <= depth_o - 2'h1;
            tmr_reg <= svc_i;
            sp_reg <= sp_reg + 16'(STACK_VEC_BYTES);
         end else begin
            tmr_reg <= tmr_reg - 8'h01;
         end
      end
   end
endmodule // vpiu_cpu_model
